// ### vepc_pkg.sv
// Constants and types shared by the virtual enable power control block.
package vepc_pkg;

	localparam logic [7:0] VEPC_OFS_ADDR_CFG = 8'h2B;
	localparam logic [7:0] VEPC_OFS_BUS_BASE = 8'h32;
	localparam logic [7:0] VEPC_OFS_VID_BASE = 8'h33;
	localparam logic [7:0] VEPC_OFS_OFFSET_RB = 8'hDB;

	localparam int VEPC_SET_ENABLE = 0;
	localparam int VEPC_SET_RESTART = 1;
	localparam int VEPC_SET_CALCLR = 2;
	localparam int VEPC_SET_MEMRELOAD = 3;
	localparam int VEPC_SET_TESTRST = 4;

	localparam int VEPC_CFG_EN = 0;
	localparam int VEPC_CFG_APPLY_I2C = 1;
	localparam int VEPC_CFG_APPLY_VID = 2;

	localparam int VEPC_CFG_W = 3;
	localparam int VEPC_I2C_W = 7;
	localparam int VEPC_VID_W = 4;
	localparam int VEPC_OFS_W = 4;

	localparam logic [VEPC_CFG_W-1:0] VEPC_CFG_RESET = 3'h7;
	localparam logic [VEPC_I2C_W-1:0] VEPC_I2C_BASE_RESET = 7'h44;
	localparam logic [VEPC_VID_W-1:0] VEPC_VID_BASE_RESET = 4'h0;
	localparam logic [7:0] VEPC_READ_ZERO = 8'h00;

	typedef enum logic [2:0] {
		VEPC_ST_DISABLED = 3'h0,
		VEPC_ST_START = 3'h1,
		VEPC_ST_NVM = 3'h2,
		VEPC_ST_CALCLR = 3'h3,
		VEPC_ST_CAL = 3'h4,
		VEPC_ST_RUN = 3'h5
	} vepc_state_t;

endpackage : vepc_pkg

// ### vepc_addr_if.sv
// Signals between the control logic and the address offset calculator.
`timescale 1ns/100ps
interface vepc_addr_if;
	logic latchOffset;
	logic [vepc_pkg::VEPC_OFS_W-1:0] senseOffset;
	logic [vepc_pkg::VEPC_CFG_W-1:0] cfg;
	logic [vepc_pkg::VEPC_I2C_W-1:0] i2cBase;
	logic [vepc_pkg::VEPC_VID_W-1:0] vidBase;
	logic [vepc_pkg::VEPC_OFS_W-1:0] offset;
	logic [vepc_pkg::VEPC_I2C_W-1:0] i2cAddr;
	logic [vepc_pkg::VEPC_VID_W-1:0] vidAddr;

	modport ctrl (
		output latchOffset,
		output senseOffset,
		output cfg,
		output i2cBase,
		output vidBase,
		input offset,
		input i2cAddr,
		input vidAddr
	);

	modport calc (
		input latchOffset,
		input senseOffset,
		input cfg,
		input i2cBase,
		input vidBase,
		output offset,
		output i2cAddr,
		output vidAddr
	);
endinterface : vepc_addr_if

// ### vepc_sync.sv
// Two flip-flop synchroniser for a static multi-bit pin level.
`timescale 1ns/100ps
module vepc_sync #(
	parameter int WIDTH = 4
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= d;
			sync_q <= meta_q;
		end
	end

	// The resistor code is static, so bits skewing by a cycle only matters before latching.
	assign q = sync_q;
endmodule : vepc_sync

// ### vepc_addr.sv
// Address offset latch and effective bus address calculation.
`timescale 1ns/100ps
module vepc_addr (
	input wire logic ref_clk,
	input wire logic rst_n,
	vepc_addr_if.calc bus
);
	import vepc_pkg::*;

	logic [VEPC_OFS_W-1:0] offset_q;
	logic [VEPC_OFS_W-1:0] offset_d;
	logic [VEPC_I2C_W-1:0] i2cAddr_q;
	logic [VEPC_I2C_W-1:0] i2cAddr_d;
	logic [VEPC_VID_W-1:0] vidAddr_q;
	logic [VEPC_VID_W-1:0] vidAddr_d;
	logic [VEPC_OFS_W-1:0] ofsI2c;
	logic [VEPC_OFS_W-1:0] ofsVid;

	always_comb begin
		offset_d = offset_q;
		if (bus.latchOffset) begin
			offset_d = bus.cfg[VEPC_CFG_EN] ? bus.senseOffset : '0;
		end
		ofsI2c = (bus.cfg[VEPC_CFG_EN] && bus.cfg[VEPC_CFG_APPLY_I2C]) ? offset_q : '0;
		ofsVid = (bus.cfg[VEPC_CFG_EN] && bus.cfg[VEPC_CFG_APPLY_VID]) ? offset_q : '0;
		i2cAddr_d = bus.i2cBase + {3'h0, ofsI2c};
		vidAddr_d = bus.vidBase + ofsVid;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			offset_q <= '0;
			i2cAddr_q <= VEPC_I2C_BASE_RESET;
			vidAddr_q <= VEPC_VID_BASE_RESET;
		end else begin
			offset_q <= offset_d;
			i2cAddr_q <= i2cAddr_d;
			vidAddr_q <= vidAddr_d;
		end
	end

	assign bus.offset = offset_q;
	assign bus.i2cAddr = i2cAddr_q;
	assign bus.vidAddr = vidAddr_q;
endmodule : vepc_addr

// ### vepc_top.sv
// Virtual enable power sequencer with address offset configuration registers.
// Contract
// - Setting byte: test, mem, cal, restart, enable.
// - Enable leaves disabled; zero enable without restart disables.
// - Restart with enable zero re-cycles power-up.
// - Calibration clear bit forces recalibration.
// - Clear bit zero keeps and skips calibration.
// - Calibrate anyway if never calibrated before.
// - Reload: POR defaults, then NVM load.
// - No reload leaves working registers untouched.
// - Test reset bit clears test registers.
// - All-zero byte disables; registers stay writable.
// - Add zero-to-fifteen offset to bus addresses.
// - Offset config register holds three flags.
// - Voltage-ID apply flag adds offset, default on.
// - I2C apply flag adds offset, default on.
// - Seven-bit I2C base, default 68.
// - Offset latched only during NVM initialisation.
`timescale 1ns/100ps
module vepc_top (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic powerCmdValid,
	input wire logic [7:0] powerSetting,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	output logic regRdValid,
	input wire logic [vepc_pkg::VEPC_OFS_W-1:0] offsetSense,
	input wire logic nvmLoadDone,
	input wire logic calDone,
	output logic deviceDisabled,
	output logic deviceRunning,
	output logic workRegPorLoad,
	output logic nvmLoadReq,
	output logic testRegClear,
	output logic calibrationClear,
	output logic calReq,
	output logic calValid,
	output logic [vepc_pkg::VEPC_I2C_W-1:0] i2cAddr,
	output logic [vepc_pkg::VEPC_VID_W-1:0] vidAddr,
	output logic [vepc_pkg::VEPC_OFS_W-1:0] addrOffset
);
	import vepc_pkg::*;

	vepc_addr_if addrIf ();

	logic [VEPC_OFS_W-1:0] senseSync;

	vepc_sync #(
		.WIDTH(VEPC_OFS_W)
	) u_sense_sync (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.d(offsetSense),
		.q(senseSync)
	);

	vepc_addr u_addr (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.bus(addrIf.calc)
	);

	// Sequencer state.
	vepc_state_t state_q;
	vepc_state_t state_d;
	logic flagTest_q;
	logic flagTest_d;
	logic flagMem_q;
	logic flagMem_d;
	logic flagCal_q;
	logic flagCal_d;
	logic calOnce_q;
	logic calOnce_d;
	logic porLoad_q;
	logic porLoad_d;
	logic testClr_q;
	logic testClr_d;
	logic calClear_q;
	logic calClear_d;
	logic offsetLatch_q;
	logic offsetLatch_d;
	logic nvmReq_q;
	logic nvmReq_d;
	logic calReq_q;
	logic calReq_d;
	logic disabled_q;
	logic disabled_d;
	logic running_q;
	logic running_d;

	logic setEnable;
	logic setRestart;
	logic goUp;
	logic goDown;
	logic needCal;
	vepc_state_t calStep;

	always_comb begin
		setEnable = powerSetting[VEPC_SET_ENABLE];
		setRestart = powerSetting[VEPC_SET_RESTART];
		goUp = 1'b0;
		goDown = 1'b0;
		if (powerCmdValid) begin
			if (state_q == VEPC_ST_DISABLED) begin
				goUp = setEnable | setRestart;
			end else if (!setEnable) begin
				goUp = setRestart;
				goDown = !setRestart;
			end
		end
		needCal = flagCal_q | !calOnce_q;
		calStep = needCal ? VEPC_ST_CALCLR : VEPC_ST_RUN;

		state_d = state_q;
		flagTest_d = flagTest_q;
		flagMem_d = flagMem_q;
		flagCal_d = flagCal_q;
		calOnce_d = calOnce_q;
		porLoad_d = 1'b0;
		testClr_d = 1'b0;
		calClear_d = 1'b0;
		offsetLatch_d = 1'b0;

		if (goUp) begin
			flagTest_d = powerSetting[VEPC_SET_TESTRST];
			flagMem_d = powerSetting[VEPC_SET_MEMRELOAD];
			flagCal_d = powerSetting[VEPC_SET_CALCLR];
			state_d = VEPC_ST_START;
		end else if (goDown) begin
			state_d = VEPC_ST_DISABLED;
		end else begin
			case (state_q)
				VEPC_ST_START: begin
					porLoad_d = flagMem_q;
					testClr_d = flagTest_q;
					state_d = flagMem_q ? VEPC_ST_NVM : calStep;
				end
				VEPC_ST_NVM: begin
					if (nvmLoadDone) begin
						offsetLatch_d = 1'b1;
						state_d = calStep;
					end
				end
				VEPC_ST_CALCLR: begin
					calClear_d = 1'b1;
					state_d = VEPC_ST_CAL;
				end
				VEPC_ST_CAL: begin
					if (calDone) begin
						calOnce_d = 1'b1;
						state_d = VEPC_ST_RUN;
					end
				end
				VEPC_ST_RUN: begin
					state_d = VEPC_ST_RUN;
				end
				VEPC_ST_DISABLED: begin
					state_d = VEPC_ST_DISABLED;
				end
				default: begin
					state_d = VEPC_ST_DISABLED;
				end
			endcase
		end
		nvmReq_d = (state_d == VEPC_ST_NVM);
		calReq_d = (state_d == VEPC_ST_CAL);
		disabled_d = (state_d == VEPC_ST_DISABLED);
		running_d = (state_d == VEPC_ST_RUN);
	end

	// Reset behaves like the real enable pin: a full power-up with every option set.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= VEPC_ST_START;
			flagTest_q <= 1'b1;
			flagMem_q <= 1'b1;
			flagCal_q <= 1'b1;
			calOnce_q <= 1'b0;
			porLoad_q <= 1'b0;
			testClr_q <= 1'b0;
			calClear_q <= 1'b0;
			offsetLatch_q <= 1'b0;
			nvmReq_q <= 1'b0;
			calReq_q <= 1'b0;
			disabled_q <= 1'b0;
			running_q <= 1'b0;
		end else begin
			state_q <= state_d;
			flagTest_q <= flagTest_d;
			flagMem_q <= flagMem_d;
			flagCal_q <= flagCal_d;
			calOnce_q <= calOnce_d;
			porLoad_q <= porLoad_d;
			testClr_q <= testClr_d;
			calClear_q <= calClear_d;
			offsetLatch_q <= offsetLatch_d;
			nvmReq_q <= nvmReq_d;
			calReq_q <= calReq_d;
			disabled_q <= disabled_d;
			running_q <= running_d;
		end
	end

	// Configuration registers.
	logic [VEPC_CFG_W-1:0] cfg_q;
	logic [VEPC_CFG_W-1:0] cfg_d;
	logic [VEPC_I2C_W-1:0] i2cBase_q;
	logic [VEPC_I2C_W-1:0] i2cBase_d;
	logic [VEPC_VID_W-1:0] vidBase_q;
	logic [VEPC_VID_W-1:0] vidBase_d;
	logic [7:0] rdData_q;
	logic [7:0] rdData_d;
	logic rdValid_q;
	logic rdValid_d;

	always_comb begin
		cfg_d = cfg_q;
		i2cBase_d = i2cBase_q;
		vidBase_d = vidBase_q;
		// The POR load wins over a write in the same cycle; the NVM copy follows it anyway.
		if (porLoad_q) begin
			cfg_d = VEPC_CFG_RESET;
			i2cBase_d = VEPC_I2C_BASE_RESET;
			vidBase_d = VEPC_VID_BASE_RESET;
		end else if (regWrEn) begin
			case (regAddr)
				VEPC_OFS_ADDR_CFG: cfg_d = regWrData[VEPC_CFG_W-1:0];
				VEPC_OFS_BUS_BASE: i2cBase_d = regWrData[VEPC_I2C_W-1:0];
				VEPC_OFS_VID_BASE: vidBase_d = regWrData[VEPC_VID_W-1:0];
				default: begin
				end
			endcase
		end
		rdValid_d = regRdEn;
		rdData_d = rdData_q;
		if (regRdEn) begin
			case (regAddr)
				VEPC_OFS_ADDR_CFG: rdData_d = {5'h00, cfg_q};
				VEPC_OFS_BUS_BASE: rdData_d = {1'h0, i2cBase_q};
				VEPC_OFS_VID_BASE: rdData_d = {4'h0, vidBase_q};
				VEPC_OFS_OFFSET_RB: rdData_d = {4'h0, addrIf.offset};
				default: rdData_d = VEPC_READ_ZERO;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q <= VEPC_CFG_RESET;
			i2cBase_q <= VEPC_I2C_BASE_RESET;
			vidBase_q <= VEPC_VID_BASE_RESET;
			rdData_q <= VEPC_READ_ZERO;
			rdValid_q <= 1'b0;
		end else begin
			cfg_q <= cfg_d;
			i2cBase_q <= i2cBase_d;
			vidBase_q <= vidBase_d;
			rdData_q <= rdData_d;
			rdValid_q <= rdValid_d;
		end
	end

	assign addrIf.latchOffset = offsetLatch_q;
	assign addrIf.senseOffset = senseSync;
	assign addrIf.cfg = cfg_q;
	assign addrIf.i2cBase = i2cBase_q;
	assign addrIf.vidBase = vidBase_q;

	assign regRdData = rdData_q;
	assign regRdValid = rdValid_q;
	assign deviceDisabled = disabled_q;
	assign deviceRunning = running_q;
	assign workRegPorLoad = porLoad_q;
	assign nvmLoadReq = nvmReq_q;
	assign testRegClear = testClr_q;
	assign calibrationClear = calClear_q;
	assign calReq = calReq_q;
	assign calValid = calOnce_q;
	assign i2cAddr = addrIf.i2cAddr;
	assign vidAddr = addrIf.vidAddr;
	assign addrOffset = addrIf.offset;
endmodule : vepc_top

// ### vepc_top_sva.sv
// Concurrent checks on the power sequencer ports.
`timescale 1ns/100ps
module vepc_top_sva (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic powerCmdValid,
	input wire logic [7:0] powerSetting,
	input wire logic regRdEn,
	input wire logic regRdValid,
	input wire logic nvmLoadReq,
	input wire logic nvmLoadDone,
	input wire logic calReq,
	input wire logic calDone,
	input wire logic calValid,
	input wire logic deviceDisabled,
	input wire logic deviceRunning,
	input wire logic workRegPorLoad,
	input wire logic testRegClear,
	input wire logic calibrationClear
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence wakeCmd;
		powerCmdValid && deviceDisabled && powerSetting[0];
	endsequence
	sequence stopCmd;
		powerCmdValid && !deviceDisabled && !powerSetting[0];
	endsequence
	// Any command that starts a power-up, a wake from disabled or a restart from operation.
	sequence upCmd;
		powerCmdValid && ((deviceDisabled && (powerSetting[0] || powerSetting[1]))
			|| (!deviceDisabled && !powerSetting[0] && powerSetting[1]));
	endsequence
	a_read_answer: assert property (regRdEn |=> regRdValid)
		else $error("read gave no valid pulse");
	a_wake_leaves: assert property (wakeCmd |=> !deviceDisabled)
		else $error("enable did not leave disabled");
	a_zero_disables: assert property (stopCmd ##0 !powerSetting[1] |=> deviceDisabled && !deviceRunning)
		else $error("zero setting did not disable");
	a_restart_cycles: assert property (stopCmd ##0 powerSetting[1] |=> !deviceDisabled && !deviceRunning)
		else $error("restart did not re-enter power-up");
	a_reload_steps: assert property (upCmd ##0 powerSetting[3] |-> ##2 workRegPorLoad && nvmLoadReq)
		else $error("reload steps missing");
	a_keep_regs: assert property (wakeCmd ##0 !powerSetting[3] |-> ##2 !workRegPorLoad && !nvmLoadReq)
		else $error("working registers disturbed");
	a_test_clear: assert property (upCmd ##0 powerSetting[4] |-> ##2 testRegClear)
		else $error("test registers not cleared");
	a_cal_clear: assert property ($rose(calReq) |-> calibrationClear)
		else $error("calibration state not cleared before calibrating");
	a_nvm_release: assert property (nvmLoadReq && nvmLoadDone |=> !nvmLoadReq)
		else $error("memory request not released");
	a_cal_finish: assert property (calReq && calDone |=> !calReq && deviceRunning && calValid)
		else $error("calibration end not handled");
	a_skip_cal: assert property (wakeCmd ##0 powerSetting[3:2] == 2'h0 && calValid |-> ##[2:3] deviceRunning)
		else $error("calibration not skipped");
	a_must_cal: assert property (wakeCmd ##0 !powerSetting[2] && !calValid |-> ##[2:4] calReq)
		else $error("first calibration skipped");
endmodule : vepc_top_sva

// ### vepc_far_model.sv
// Memory loader and calibrator answering the sequencer's requests.
`timescale 1ns/100ps
module vepc_far_model (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic nvmLoadReq,
	input wire logic calReq,
	output logic nvmLoadDone,
	output logic calDone
);
	logic [3:0] nvmCnt_q;
	logic [3:0] calCnt_q;
	logic [3:0] lat;
	assign lat = slow ? 4'h6 : 4'h1;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			nvmCnt_q <= 4'h0;
			calCnt_q <= 4'h0;
			nvmLoadDone <= 1'b0;
			calDone <= 1'b0;
		end else begin
			nvmCnt_q <= (nvmLoadReq && !nvmLoadDone) ? nvmCnt_q + 4'h1 : 4'h0;
			calCnt_q <= (calReq && !calDone) ? calCnt_q + 4'h1 : 4'h0;
			nvmLoadDone <= nvmLoadReq && !nvmLoadDone && nvmCnt_q == lat;
			calDone <= calReq && !calDone && calCnt_q == lat;
		end
	end
endmodule : vepc_far_model

// ### tb_virtual_enable_power_control.sv
// Self-checking bench for the virtual enable power sequencer.
`timescale 1ns/100ps
module tb_virtual_enable_power_control;
	import vepc_pkg::*;
	logic ref_clk, rst_n, powerCmdValid, regWrEn, regRdEn, regRdValid;
	logic nvmLoadDone, calDone, slow, deviceDisabled, deviceRunning;
	logic workRegPorLoad, nvmLoadReq, testRegClear, calibrationClear, calReq, calValid;
	logic [7:0] powerSetting, regAddr, regWrData, regRdData;
	logic [VEPC_I2C_W-1:0] i2cAddr;
	logic [VEPC_VID_W-1:0] vidAddr, addrOffset, offsetSense;
	int nFail = 0;
	int checkCount = 0;
	vepc_top dut_u (.ref_clk, .rst_n, .powerCmdValid, .powerSetting, .regWrEn, .regRdEn,
		.regAddr, .regWrData, .regRdData, .regRdValid, .offsetSense, .nvmLoadDone, .calDone,
		.deviceDisabled, .deviceRunning, .workRegPorLoad, .nvmLoadReq, .testRegClear,
		.calibrationClear, .calReq, .calValid, .i2cAddr, .vidAddr, .addrOffset);
	vepc_far_model far_u (.ref_clk, .rst_n, .slow, .nvmLoadReq, .calReq, .nvmLoadDone, .calDone);
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		checkCount++;
		if (got !== exp) begin
			nFail++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(negedge ref_clk);
		regWrEn = 1'b0;
		repeat (2) @(negedge ref_clk);
	endtask : reg_write
	task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
		regAddr = a;
		regRdEn = 1'b1;
		@(negedge ref_clk);
		// The valid flag is a single-cycle pulse, so it is looked at in the cycle after the strobe.
		regRdEn = 1'b0;
		check("read valid", 8'h01, {7'h00, regRdValid});
		check("read data", exp, regRdData);
		@(negedge ref_clk);
	endtask : reg_read
	task automatic power(input logic [7:0] s);
		powerSetting = s;
		powerCmdValid = 1'b1;
		@(negedge ref_clk);
		powerCmdValid = 1'b0;
	endtask : power
	task automatic wait_run();
		for (int i = 0; i < 100 && deviceRunning !== 1'b1; i++) @(negedge ref_clk);
		check("running", 8'h01, {7'h00, deviceRunning});
	endtask : wait_run
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", checkCount, nFail);
		if (nFail == 0 && checkCount > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (5000) @(posedge ref_clk);
		nFail++;
		print_verdict();
	end
	initial begin
		{rst_n, powerCmdValid, regWrEn, regRdEn, slow} = 5'h00;
		{powerSetting, regAddr, regWrData} = 24'h000000;
		offsetSense = 4'h5;
		repeat (5) @(negedge ref_clk);
		rst_n = 1'b1;
		wait_run();
		reg_read(VEPC_OFS_ADDR_CFG, 8'h07);
		reg_read(VEPC_OFS_BUS_BASE, 8'h44);
		reg_read(VEPC_OFS_VID_BASE, 8'h00);
		reg_read(VEPC_OFS_OFFSET_RB, 8'h05);
		reg_read(8'h10, 8'h00);
		check("i2c addr", 8'h49, {1'b0, i2cAddr});
		check("vid addr", 8'h05, {4'h0, vidAddr});
		reg_write(VEPC_OFS_BUS_BASE, 8'h50);
		reg_write(VEPC_OFS_VID_BASE, 8'h0E);
		check("vid wrap", 8'h03, {4'h0, vidAddr});
		reg_write(VEPC_OFS_ADDR_CFG, 8'h05);
		check("i2c no apply", 8'h50, {1'b0, i2cAddr});
		reg_write(VEPC_OFS_ADDR_CFG, 8'h03);
		check("vid no apply", 8'h0E, {4'h0, vidAddr});
		offsetSense = 4'h9;
		power(8'h00);
		check("disabled", 8'h01, {7'h00, deviceDisabled});
		reg_write(VEPC_OFS_BUS_BASE, 8'h60);
		reg_read(VEPC_OFS_BUS_BASE, 8'h60);
		power(8'hE1);
		wait_run();
		check("offset kept", 8'h05, {4'h0, addrOffset});
		reg_read(VEPC_OFS_BUS_BASE, 8'h60);
		power(8'h01);
		check("enable ignored", 8'h01, {7'h00, deviceRunning});
		@(negedge ref_clk);
		power(8'h02);
		check("restart", 8'h00, {6'h00, deviceDisabled, deviceRunning});
		wait_run();
		slow = 1'b1;
		power(8'h1E);
		wait_run();
		reg_read(VEPC_OFS_BUS_BASE, 8'h44);
		reg_read(VEPC_OFS_OFFSET_RB, 8'h09);
		check("i2c relatched", 8'h4D, {1'b0, i2cAddr});
		rst_n = 1'b0;
		@(negedge ref_clk);
		rst_n = 1'b1;
		power(8'h00);
		@(negedge ref_clk);
		power(8'h01);
		wait_run();
		check("cal valid", 8'h01, {7'h00, calValid});
		print_verdict();
	end
endmodule : tb_virtual_enable_power_control
bind vepc_top vepc_top_sva chk_u (.ref_clk, .rst_n, .powerCmdValid, .powerSetting, .regRdEn,
	.regRdValid, .nvmLoadReq, .nvmLoadDone, .calReq, .calDone, .calValid, .deviceDisabled,
	.deviceRunning, .workRegPorLoad, .testRegClear, .calibrationClear);
